// ### sbcwd_watchdog_top.v
// watchdog with its control, status and persistent configuration registers
// assumes chip_mode_in, rxd_level_in, fail clear and nv image are on clk_sys_in
`timescale 1ns/1ns
`include "sbcwd_defs.vh"

module sbcwd_watchdog_top #(
  parameter TICK_CYCLES = `SBCWD_TICK_NS / `SBCWD_CLK_NS,
  parameter PRESC_W     = 17
) (
  input  wire       clk_sys_in,
  input  wire       reset_in,
  input  wire       ce_in,
  input  wire       spi_csn_in,
  input  wire       spi_sck_in,
  input  wire       spi_sdi_in,
  output wire       spi_sdo_out,
  output wire       spi_sdo_oe_out,
  input  wire [2:0] chip_mode_in,
  input  wire       rxd_level_in,
  input  wire       spi_fail_enable_in,
  input  wire       wdog_fail_clear_in,
  input  wire       nv_image_valid_in,
  input  wire [7:0] nv_image_in,
  output reg  [7:0] nv_image_out,
  output reg        nv_write_out,
  output reg        spi_fail_out,
  output reg        reset_req_out,
  output reg  [4:0] reset_cause_code_out,
  output reg        wdog_fail_pending_out,
  output wire       forced_normal_state_out,
  output wire       sw_dev_state_out,
  output wire [1:0] uv_threshold_select_out,
  output wire       sleep_inhibit_out
);

  localparam [1:0] BEH_OFF     = 2'h0;
  localparam [1:0] BEH_TIMEOUT = 2'h1;
  localparam [1:0] BEH_WINDOW  = 2'h2;
  // prescaler end count, cut to the counter width on purpose
  localparam integer       TICK_LAST_I = TICK_CYCLES - 1;
  localparam [PRESC_W-1:0] TICK_LAST   = TICK_LAST_I[PRESC_W-1:0];

  reg  [2:0]  wdog_mode_select_reg;
  reg  [3:0]  wdog_period_select_reg;
  reg  [7:0]  cfg_reg;
  reg         load_pend_reg;
  reg  [PRESC_W-1:0] presc_reg;
  reg  [12:0] ms_cnt_reg;
  reg  [1:0]  beh_reg;
  reg  [1:0]  beh_next;
  reg  [7:0]  rd_data;
  wire [6:0]  rd_addr;
  wire        frame_done;
  wire        frame_bad;
  wire [6:0]  frame_addr;
  wire        frame_ro;
  wire [7:0]  frame_wdata;

  sbcwd_spi_slave u_spi (
    .clk_sys_in     (clk_sys_in),
    .reset_in       (reset_in),
    .ce_in          (ce_in),
    .spi_csn_in     (spi_csn_in),
    .spi_sck_in     (spi_sck_in),
    .spi_sdi_in     (spi_sdi_in),
    .rd_data_in     (rd_data),
    .rd_addr_out    (rd_addr),
    .frame_done_out (frame_done),
    .frame_bad_out  (frame_bad),
    .addr_out       (frame_addr),
    .read_only_out  (frame_ro),
    .wdata_out      (frame_wdata),
    .sdo_out        (spi_sdo_out),
    .sdo_oe_out     (spi_sdo_oe_out)
  );

  // nominal period in ms; zero marks a redundant, illegal code
  function [12:0] period_ms;
    input [3:0] code;
    begin
      case (code)
        `SBCWD_PER_8:    period_ms = `SBCWD_MS_8;
        `SBCWD_PER_16:   period_ms = `SBCWD_MS_16;
        `SBCWD_PER_32:   period_ms = `SBCWD_MS_32;
        `SBCWD_PER_64:   period_ms = `SBCWD_MS_64;
        `SBCWD_PER_128:  period_ms = `SBCWD_MS_128;
        `SBCWD_PER_256:  period_ms = `SBCWD_MS_256;
        `SBCWD_PER_1024: period_ms = `SBCWD_MS_1024;
        `SBCWD_PER_4096: period_ms = `SBCWD_MS_4096;
        default:         period_ms = 13'h0000;
      endcase
    end
  endfunction

  // config bits as the watchdog sees them; forced normal masks all modes
  wire forced_normal_state         = cfg_reg[`SBCWD_CFG_FN_BIT];
  wire sw_dev_state         = cfg_reg[`SBCWD_CFG_SD_BIT];
  wire chip_normal = (chip_mode_in == `SBCWD_CHIP_NORMAL);
  wire chip_stby   = (chip_mode_in == `SBCWD_CHIP_STANDBY);
  wire chip_sleep  = (chip_mode_in == `SBCWD_CHIP_SLEEP);

  assign forced_normal_state_out = forced_normal_state;
  assign sw_dev_state_out        = sw_dev_state;
  assign uv_threshold_select_out = cfg_reg[`SBCWD_CFG_UV_HI:`SBCWD_CFG_UV_LO];
  assign sleep_inhibit_out       = cfg_reg[`SBCWD_CFG_SLP_BIT];

  // behaviour the watchdog takes from settings, chip mode and rxd
  // mode field changes only reach here after an accepted write or a stored image load with sw-dev set
  always @*
  begin
    beh_next = BEH_OFF;
    if (!forced_normal_state)
    begin
      case (wdog_mode_select_reg)
        `SBCWD_MODE_WINDOW:
          if (chip_normal)
            beh_next = BEH_WINDOW;
          else if (chip_stby || chip_sleep)
            beh_next = BEH_TIMEOUT;
        `SBCWD_MODE_TIMEOUT:
          if (chip_normal || chip_stby || chip_sleep)
            beh_next = BEH_TIMEOUT;
        `SBCWD_MODE_AUTO:
          if (!sw_dev_state && (chip_normal || (chip_stby && !rxd_level_in)))
            beh_next = BEH_TIMEOUT;
        default:
          beh_next = BEH_OFF;
      endcase
    end
  end

  // timer position and its halves
  // every period is an even number of ms, so the halves are exact
  wire [12:0] per_ms      = period_ms(wdog_period_select_reg);
  wire        first_half  = (ms_cnt_reg < {1'b0, per_ms[12:1]});
  wire        tick        = (presc_reg == TICK_LAST);
  wire        overflow    = (beh_reg != BEH_OFF) && tick &&
                            (ms_cnt_reg == per_ms - 13'h0001);
  wire [1:0]  phase       = (beh_reg == BEH_OFF) ? `SBCWD_PHASE_OFF :
                            first_half ? `SBCWD_PHASE_FIRST : `SBCWD_PHASE_SECOND;

  // decode of a completed write frame
  // a refused write keeps none of its fields, not even a valid one
  wire        wr_frame    = frame_done && !frame_ro && !load_pend_reg;
  wire        wr_ctrl     = wr_frame && (frame_addr == `SBCWD_ADDR_WDOG_CTRL);
  wire        wr_cfg      = wr_frame && (frame_addr == `SBCWD_ADDR_CHIP_CFG);
  wire [2:0]  new_mode    = frame_wdata[`SBCWD_MODE_HI:`SBCWD_MODE_LO];
  wire [3:0]  new_per     = frame_wdata[`SBCWD_PER_HI:`SBCWD_PER_LO];
  wire        mode_ok     = (new_mode == `SBCWD_MODE_AUTO) ||
                            (new_mode == `SBCWD_MODE_TIMEOUT) ||
                            (new_mode == `SBCWD_MODE_WINDOW);
  wire        code_bad    = !mode_ok || (period_ms(new_per) == 13'h0000);
  wire        illegal_chg = chip_normal && (new_mode != wdog_mode_select_reg);
  wire        trigger     = wr_ctrl && !code_bad && !illegal_chg;

  // register read mux; reserved bits and unmapped addresses read zero
  // the front end latches this mid-frame, so a read shows live state
  always @*
  begin
    case (rd_addr)
      `SBCWD_ADDR_WDOG_CTRL:
        rd_data = {wdog_mode_select_reg, 1'b0, wdog_period_select_reg};
      `SBCWD_ADDR_WDOG_STATE:
        rd_data = {4'h0, forced_normal_state, sw_dev_state, phase};
      `SBCWD_ADDR_CHIP_CFG:
        rd_data = {2'h0, cfg_reg[5:2], 1'b0, cfg_reg[0]};
      default:
        rd_data = 8'h00;
    endcase
  end

  // registers, timer and reset requests; one process keeps one driver each
  always @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      // timeout mode, default period, factory config until the image loads
      wdog_mode_select_reg   <= `SBCWD_MODE_TIMEOUT;
      wdog_period_select_reg <= `SBCWD_PER_DEFAULT;
      cfg_reg                <= `SBCWD_CFG_PRESET;
      load_pend_reg          <= 1'b1;
      presc_reg              <= {PRESC_W{1'b0}};
      ms_cnt_reg             <= 13'h0000;
      beh_reg                <= BEH_OFF;
      nv_image_out           <= `SBCWD_CFG_PRESET;
      nv_write_out           <= 1'b0;
      spi_fail_out           <= 1'b0;
      reset_req_out          <= 1'b0;
      reset_cause_code_out   <= 5'h00;
      wdog_fail_pending_out  <= 1'b0;
    end
    else if (ce_in)
    begin
      nv_write_out  <= 1'b0;
      spi_fail_out  <= 1'b0;
      reset_req_out <= 1'b0;
      beh_reg       <= beh_next;
      if (load_pend_reg)
      begin
        // stored image is restored once after reset; sw-dev picks autonomous mode
        load_pend_reg <= 1'b0;
        if (nv_image_valid_in)
        begin
          cfg_reg      <= nv_image_in;
          nv_image_out <= nv_image_in;
          if (nv_image_in[`SBCWD_CFG_SD_BIT])
            wdog_mode_select_reg <= `SBCWD_MODE_AUTO;
        end
      end

      // config write: the whole byte goes to the working copy and the store
      if (wr_cfg)
      begin
        cfg_reg      <= frame_wdata;
        nv_image_out <= frame_wdata;
        nv_write_out <= 1'b1;
      end

      // bad code or wrong bit count; the pulse only leaves when enabled
      if ((wr_ctrl && code_bad) || frame_bad)
        spi_fail_out <= spi_fail_enable_in;

      // mode change in normal is refused and asks for a reset instead
      if (wr_ctrl && !code_bad && illegal_chg)
      begin
        reset_req_out        <= 1'b1;
        reset_cause_code_out <= `SBCWD_CAUSE_ILLEGAL;
      end

      // accepted write: a window trigger in the first half still resets
      if (trigger)
      begin
        wdog_mode_select_reg   <= new_mode;
        wdog_period_select_reg <= new_per;
        if (beh_reg == BEH_WINDOW && first_half)
        begin
          reset_req_out        <= 1'b1;
          reset_cause_code_out <= `SBCWD_CAUSE_EARLY;
        end
      end

      // a trigger or any behaviour change starts the period from zero
      // an off watchdog is held at zero so it starts clean when enabled
      if (trigger || beh_next != beh_reg || beh_reg == BEH_OFF)
      begin
        presc_reg  <= {PRESC_W{1'b0}};
        ms_cnt_reg <= 13'h0000;
      end
      else if (tick)
      begin
        presc_reg  <= {PRESC_W{1'b0}};
        ms_cnt_reg <= overflow ? 13'h0000 : ms_cnt_reg + 13'h0001;
      end
      else
        presc_reg <= presc_reg + {{(PRESC_W-1){1'b0}}, 1'b1};

      // overflow handling; a set in the clear cycle wins over the clear
      if (overflow && !trigger && beh_reg == BEH_WINDOW)
      begin
        reset_req_out        <= 1'b1;
        reset_cause_code_out <= `SBCWD_CAUSE_OVERFLOW;
      end
      // timeout overflow: outside sleep the first only flags, a pending one resets
      if (overflow && !trigger && beh_reg == BEH_TIMEOUT)
      begin
        wdog_fail_pending_out <= 1'b1;
        if (chip_sleep)
        begin
          reset_req_out        <= 1'b1; // overflow in sleep wakes the host
          reset_cause_code_out <= `SBCWD_CAUSE_SLEEP_OVF;
        end
        else if (wdog_fail_pending_out)
        begin
          reset_req_out        <= 1'b1;
          reset_cause_code_out <= `SBCWD_CAUSE_OVERFLOW;
        end
      end
      else if (wdog_fail_clear_in)
        wdog_fail_pending_out <= 1'b0;
    end
  end

endmodule

// ### sbcwd_defs.vh
// register map, field positions, codes and timing for the watchdog block
// definitions only; included by bare name from the design files
`ifndef SBCWD_DEFS_VH
`define SBCWD_DEFS_VH

// register addresses (7-bit spi address field)
`define SBCWD_ADDR_WDOG_CTRL   7'h00
`define SBCWD_ADDR_WDOG_STATE  7'h05
`define SBCWD_ADDR_CHIP_CFG    7'h74

// spi frame: 7 address bits, read-only flag, 8 data bits
`define SBCWD_FRAME_BITS       5'h10
`define SBCWD_ADDR_BITS_M1     5'h07

// watchdog_control fields
`define SBCWD_MODE_HI          7
`define SBCWD_MODE_LO          5
`define SBCWD_PER_HI           3
`define SBCWD_PER_LO           0

// persistent_chip_config fields
`define SBCWD_CFG_UV_HI        5
`define SBCWD_CFG_UV_LO        4
`define SBCWD_CFG_FN_BIT       3
`define SBCWD_CFG_SD_BIT       2
`define SBCWD_CFG_SLP_BIT      0
`define SBCWD_CFG_PRESET       8'h08

// watchdog mode codes
`define SBCWD_MODE_AUTO        3'h1
`define SBCWD_MODE_TIMEOUT     3'h2
`define SBCWD_MODE_WINDOW      3'h4

// period codes and their length in ms
`define SBCWD_PER_8            4'h8
`define SBCWD_PER_16           4'h1
`define SBCWD_PER_32           4'h2
`define SBCWD_PER_64           4'hb
`define SBCWD_PER_128          4'h4
`define SBCWD_PER_256          4'hd
`define SBCWD_PER_1024         4'he
`define SBCWD_PER_4096         4'h7
`define SBCWD_PER_DEFAULT      4'h4
`define SBCWD_MS_8             13'h0008
`define SBCWD_MS_16            13'h0010
`define SBCWD_MS_32            13'h0020
`define SBCWD_MS_64            13'h0040
`define SBCWD_MS_128           13'h0080
`define SBCWD_MS_256           13'h0100
`define SBCWD_MS_1024          13'h0400
`define SBCWD_MS_4096          13'h1000

// watchdog phase codes
`define SBCWD_PHASE_OFF        2'h0
`define SBCWD_PHASE_FIRST      2'h1
`define SBCWD_PHASE_SECOND     2'h2

// chip operating mode codes seen on chip_mode_in
`define SBCWD_CHIP_SLEEP       3'h1
`define SBCWD_CHIP_STANDBY     3'h4
`define SBCWD_CHIP_NORMAL      3'h7

// reset cause codes
`define SBCWD_CAUSE_SLEEP_OVF  5'h0c
`define SBCWD_CAUSE_EARLY      5'h0e
`define SBCWD_CAUSE_OVERFLOW   5'h0f
`define SBCWD_CAUSE_ILLEGAL    5'h10

// timebase: system clock period and watchdog tick, both in ns
`define SBCWD_CLK_NS           8
`define SBCWD_TICK_NS          1000000

`endif

// ### sbcwd_spi_slave.v
// spi slave front end: 16-bit frames, msb first, data taken on sck rise
// assumes csn, sck and sdi are asynchronous pins; sck well below clk/6
`timescale 1ns/1ns
`include "sbcwd_defs.vh"

module sbcwd_spi_slave (
  input  wire       clk_sys_in,
  input  wire       reset_in,
  input  wire       ce_in,
  input  wire       spi_csn_in,
  input  wire       spi_sck_in,
  input  wire       spi_sdi_in,
  input  wire [7:0] rd_data_in,
  output wire [6:0] rd_addr_out,
  output reg        frame_done_out,
  output reg        frame_bad_out,
  output reg  [6:0] addr_out,
  output reg        read_only_out,
  output reg  [7:0] wdata_out,
  output reg        sdo_out,
  output wire       sdo_oe_out
);

  localparam [2:0] PIN_IDLE = 3'h4; // csn idle high, sck and sdi low

  wire [2:0] pin_raw;
  reg  [2:0] sync1_reg;
  reg  [2:0] sync2_reg;
  reg  [2:0] sync3_reg;
  reg  [2:0] stable_reg;
  reg  [2:0] stable_d_reg;
  reg  [4:0] bit_cnt_reg;
  reg  [15:0] shift_reg;
  reg  [7:0] shadow_reg;

  assign pin_raw = {spi_csn_in, spi_sck_in, spi_sdi_in};

  // three-stage sync per pin; a change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_sync
      always @(posedge clk_sys_in)
      begin
        if (reset_in)
        begin
          sync1_reg[gi]    <= PIN_IDLE[gi];
          sync2_reg[gi]    <= PIN_IDLE[gi];
          sync3_reg[gi]    <= PIN_IDLE[gi];
          stable_reg[gi]   <= PIN_IDLE[gi];
          stable_d_reg[gi] <= PIN_IDLE[gi];
        end
        else if (ce_in)
        begin
          sync1_reg[gi]    <= pin_raw[gi];
          sync2_reg[gi]    <= sync1_reg[gi];
          sync3_reg[gi]    <= sync2_reg[gi];
          if (sync2_reg[gi] == sync3_reg[gi])
            stable_reg[gi] <= sync3_reg[gi];
          stable_d_reg[gi] <= stable_reg[gi];
        end
      end
    end
  endgenerate

  wire sel      = ~stable_reg[2];
  wire sck_rise = sel & stable_reg[1] & ~stable_d_reg[1];
  wire sck_fall = sel & ~stable_reg[1] & stable_d_reg[1];
  wire csn_fall = ~stable_reg[2] & stable_d_reg[2];
  wire csn_rise = stable_reg[2] & ~stable_d_reg[2];

  // address is complete after seven bits; read data is fetched then
  assign rd_addr_out = shift_reg[6:0];
  assign sdo_oe_out  = sel;

  // frame shifter; anything but exactly sixteen clocks marks the frame bad
  always @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      bit_cnt_reg    <= 5'h00;
      shift_reg      <= 16'h0000;
      shadow_reg     <= 8'h00;
      sdo_out        <= 1'b0;
      frame_done_out <= 1'b0;
      frame_bad_out  <= 1'b0;
      addr_out       <= 7'h00;
      read_only_out  <= 1'b1;
      wdata_out      <= 8'h00;
    end
    else if (ce_in)
    begin
      frame_done_out <= 1'b0;
      frame_bad_out  <= 1'b0;
      if (csn_fall)
      begin
        bit_cnt_reg <= 5'h00;
        sdo_out     <= 1'b0;
      end
      else if (sck_rise)
      begin
        shift_reg <= {shift_reg[14:0], stable_reg[0]};
        if (bit_cnt_reg == `SBCWD_ADDR_BITS_M1)
          shadow_reg <= rd_data_in;
        if (bit_cnt_reg <= `SBCWD_FRAME_BITS) // saturate past a full frame
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
      end
      else if (sck_fall)
      begin
        // read data goes out during the data byte, msb first
        if (bit_cnt_reg[4:3] == 2'h1)
          sdo_out <= shadow_reg[3'h7 - bit_cnt_reg[2:0]];
        else
          sdo_out <= 1'b0;
      end
      if (csn_rise)
      begin
        frame_done_out <= (bit_cnt_reg == `SBCWD_FRAME_BITS);
        frame_bad_out  <= (bit_cnt_reg != `SBCWD_FRAME_BITS);
        addr_out       <= shift_reg[15:9];
        read_only_out  <= shift_reg[8];
        wdata_out      <= shift_reg[7:0];
      end
    end
  end

endmodule

// ### sbcwd_checker.sv
// port-level checker for the watchdog block with its registers
// assumes one clk_sys_in domain with synchronous reset_in
`timescale 1ns/1ns

module sbcwd_checker #(
  parameter TICK_CYCLES = 10
) (
  input wire       clk_sys_in,
  input wire       reset_in,
  input wire       spi_csn_in,
  input wire       spi_sdo_oe_out,
  input wire       spi_fail_enable_in,
  input wire       wdog_fail_clear_in,
  input wire       spi_fail_out,
  input wire       nv_write_out,
  input wire       reset_req_out,
  input wire [4:0] reset_cause_code_out,
  input wire       wdog_fail_pending_out,
  input wire       forced_normal_state_out
);
  // single domain, so clock and disable are stated once
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (reset_in);

  a_req_one_pulse: assert property (reset_req_out |=> !reset_req_out)
    else $error("reset request wider than one cycle");
  a_nvw_one_pulse: assert property (nv_write_out |=> !nv_write_out)
    else $error("store pulse wider than one cycle");
  a_fail_one_pulse: assert property (spi_fail_out |=> !spi_fail_out)
    else $error("spi failure pulse wider than one cycle");
  a_fail_gated: assert property (spi_fail_out |-> $past(spi_fail_enable_in))
    else $error("spi failure reported while disabled");
  a_cause_known: assert property (reset_req_out |->
    reset_cause_code_out inside {5'h0c, 5'h0e, 5'h0f, 5'h10})
    else $error("reset request with unknown cause");
  a_cause_with_req: assert property ($changed(reset_cause_code_out) |-> reset_req_out)
    else $error("cause changed without a reset request");
  a_forced_quiet: assert property (forced_normal_state_out &&
    $past(forced_normal_state_out, 2) |-> !reset_req_out || reset_cause_code_out == 5'h10)
    else $error("watchdog reset while forced normal");
  a_pending_holds: assert property (wdog_fail_pending_out && !wdog_fail_clear_in
    |=> wdog_fail_pending_out)
    else $error("fail pending dropped without clear");
  a_oe_idle: assert property (spi_csn_in [*6] |-> !spi_sdo_oe_out)
    else $error("sdo driven while deselected");

  // main scenarios reached
  c_early: cover property (reset_req_out && reset_cause_code_out == 5'h0e);
  c_illegal: cover property (reset_req_out && reset_cause_code_out == 5'h10);
  c_pending: cover property ($rose(wdog_fail_pending_out));
  c_spi_fail: cover property (spi_fail_out);
endmodule

bind sbcwd_watchdog_top sbcwd_checker #(
  .TICK_CYCLES(TICK_CYCLES)
) chk_i (
  .clk_sys_in(clk_sys_in),
  .reset_in(reset_in),
  .spi_csn_in(spi_csn_in),
  .spi_sdo_oe_out(spi_sdo_oe_out),
  .spi_fail_enable_in(spi_fail_enable_in),
  .wdog_fail_clear_in(wdog_fail_clear_in),
  .spi_fail_out(spi_fail_out),
  .nv_write_out(nv_write_out),
  .reset_req_out(reset_req_out),
  .reset_cause_code_out(reset_cause_code_out),
  .wdog_fail_pending_out(wdog_fail_pending_out),
  .forced_normal_state_out(forced_normal_state_out)
);

// ### sbcwd_host_model.sv
// spi host model: 16-bit frames msb first, sdo read just before sck fall
// assumes a 125 MHz clk_sys_in, giving an 80 ns sck period
`timescale 1ns/1ns

module sbcwd_host_model (
  input  wire clk_sys_in,
  input  wire sdo_in,
  output reg  csn_out,
  output reg  sck_out,
  output reg  sdi_out
);
  // idle bus: deselected, clock low
  initial
  begin
    csn_out = 1'b1;
    sck_out = 1'b0;
    sdi_out = 1'b0;
  end

  task tick(input integer n);
    repeat (n) @(posedge clk_sys_in);
  endtask

  // five clocks a half period leaves the sampler plenty of margin
  task xfer(input [6:0] a, input rd, input [7:0] d, output [7:0] q);
    reg [15:0] w;
    integer    i;
  begin
    w = {a, rd, d};
    q = 8'h00;
    csn_out <= 1'b0;
    for (i = 15; i >= 0; i = i - 1)
    begin
      sdi_out <= w[i];
      tick(5);
      sck_out <= 1'b1;
      tick(5);
      // sdo moves about five clocks after the host drives sck low,
      // so it is read late in the high phase, not at the rise
      if (i < 8)
        q[i] = sdo_in;
      sck_out <= 1'b0;
    end
    tick(5);
    // released line shows the inverse, never a held value
    sdi_out <= ~w[0];
    csn_out <= 1'b1;
    tick(10);
  end
  endtask
endmodule

// ### sbc_watchdog_config_bench.sv
// self-checking bench for the watchdog block and its spi host model
// assumes a 1 ms tick shortened to 100 clocks
`timescale 1ns/1ns
`include "sbcwd_defs.vh"

module sbc_watchdog_config_bench;
  reg        clk_sys_in = 1'b0;
  reg        reset_in   = 1'b1;
  reg  [2:0] chip_mode  = 3'h0;
  reg        rxd        = 1'b1;
  reg        fail_clr   = 1'b0;
  reg        fail_en    = 1'b1;
  wire       csn, sck, sdi, sdo, sdo_oe, nvw, sfail, req, fail, fn, sd, slp;
  wire [7:0] nv_img;
  wire [4:0] cause;
  wire [1:0] uv;
  integer    err_count  = 0;
  integer    checked    = 0;
  integer    cyc        = 0;
  integer    t0;
  reg  [7:0] n_req      = 8'h00;
  reg  [7:0] n_fail     = 8'h00;
  reg  [7:0] n_nvw      = 8'h00;
  reg  [7:0] base;
  reg  [7:0] q;
  localparam [31:0] PERS = 32'h812bde74;

  always #4 clk_sys_in = ~clk_sys_in;

  // cycle count and pulse tallies
  always @(posedge clk_sys_in)
  begin
    cyc <= cyc + 1;
    n_req <= n_req + {7'h0, req};
    n_fail <= n_fail + {7'h0, sfail};
    n_nvw <= n_nvw + {7'h0, nvw};
  end

  sbcwd_watchdog_top #(
    .TICK_CYCLES(100)
  ) uut (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .ce_in(1'b1),
    .spi_csn_in(csn),
    .spi_sck_in(sck),
    .spi_sdi_in(sdi),
    .spi_sdo_out(sdo),
    .spi_sdo_oe_out(sdo_oe),
    .chip_mode_in(chip_mode),
    .rxd_level_in(rxd),
    .spi_fail_enable_in(fail_en),
    .wdog_fail_clear_in(fail_clr),
    .nv_image_valid_in(1'b0),
    .nv_image_in(8'h00),
    .nv_image_out(nv_img),
    .nv_write_out(nvw),
    .spi_fail_out(sfail),
    .reset_req_out(req),
    .reset_cause_code_out(cause),
    .wdog_fail_pending_out(fail),
    .forced_normal_state_out(fn),
    .sw_dev_state_out(sd),
    .uv_threshold_select_out(uv),
    .sleep_inhibit_out(slp)
  );

  sbcwd_host_model host (
    .clk_sys_in(clk_sys_in),
    .sdo_in(sdo),
    .csn_out(csn),
    .sck_out(sck),
    .sdi_out(sdi)
  );

  task chk(input string nm, input [7:0] exp, input [7:0] got);
  begin
    checked = checked + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  end
  endtask

  task wr(input [6:0] a, input [7:0] d);
    host.xfer(a, 1'b0, d, q);
  endtask

  task rd(input [6:0] a, input [7:0] exp);
  begin
    host.xfer(a, 1'b1, 8'h00, q);
    chk("register read", exp, q);
  end
  endtask

  task upto(input integer t);
    while (cyc < t)
      @(posedge clk_sys_in);
  endtask

  task t_reset;
  begin
    rd(7'h74, 8'h08);
    rd(7'h00, 8'h44);
    rd(7'h05, 8'h08);
    rd(7'h33, 8'h00);
    chk("forced normal", 8'h01, {7'h0, fn});
    chk("uv select", 8'h00, {6'h0, uv});
    chk("sleep inhibit", 8'h00, {7'h0, slp});
  end
  endtask

  task t_cfg;
  begin
    base = n_nvw;
    wr(7'h74, 8'h31);
    chk("store pulse", base + 8'h01, n_nvw);
    chk("store image", 8'h31, nv_img);
    chk("uv select", 8'h03, {6'h0, uv});
    chk("sleep inhibit", 8'h01, {7'h0, slp});
    chk("forced normal", 8'h00, {7'h0, fn});
    rd(7'h74, 8'h31);
    wr(7'h74, 8'h00);
  end
  endtask

  // every period code, then two codes that must be refused
  task t_codes;
    integer i;
  begin
    chip_mode <= `SBCWD_CHIP_STANDBY;
    for (i = 0; i < 8; i = i + 1)
    begin
      wr(7'h00, {4'h4, PERS[31-4*i -: 4]});
      rd(7'h00, {4'h4, PERS[31-4*i -: 4]});
    end
    base = n_fail;
    wr(7'h00, 8'h68);
    wr(7'h00, 8'h49);
    chk("spi failure", base + 8'h02, n_fail);
    fail_en <= 1'b0;
    base = n_fail;
    wr(7'h00, 8'h68);
    chk("spi failure", base, n_fail);
    fail_en <= 1'b1;
    rd(7'h00, 8'h44);
  end
  endtask

  task t_timeout;
  begin
    @(posedge clk_sys_in) fail_clr <= 1'b1;
    @(posedge clk_sys_in) fail_clr <= 1'b0;
    wr(7'h00, 8'h48);
    t0 = cyc;
    rd(7'h05, 8'h01);
    upto(t0 + 420);
    rd(7'h05, 8'h02);
    upto(t0 + 660);
    chk("fail pending", 8'h00, {7'h0, fail});
    upto(t0 + 880);
    chk("fail pending", 8'h01, {7'h0, fail});
    base = n_req;
    upto(t0 + 1460);
    chk("reset request", base, n_req);
    upto(t0 + 1680);
    chk("reset request", base + 8'h01, n_req);
    chk("reset cause", 8'h0f, {3'h0, cause});
    @(posedge clk_sys_in) fail_clr <= 1'b1;
    @(posedge clk_sys_in) fail_clr <= 1'b0;
    @(posedge clk_sys_in);
    chk("fail pending", 8'h00, {7'h0, fail});
  end
  endtask

  task t_window;
  begin
    wr(7'h00, 8'h88);
    chip_mode <= `SBCWD_CHIP_NORMAL;
    base = n_req;
    wr(7'h00, 8'h88);
    chk("reset request", base + 8'h01, n_req);
    chk("reset cause", 8'h0e, {3'h0, cause});
    @(posedge clk_sys_in) chip_mode <= 3'h0;
    @(posedge clk_sys_in) chip_mode <= `SBCWD_CHIP_NORMAL;
    t0 = cyc;
    upto(t0 + 420);
    base = n_req;
    wr(7'h00, 8'h88);
    t0 = cyc;
    upto(t0 + 660);
    chk("reset request", base, n_req);
    upto(t0 + 880);
    chk("reset request", base + 8'h01, n_req);
    chk("reset cause", 8'h0f, {3'h0, cause});
    base = n_req;
    wr(7'h00, 8'h48);
    chk("reset request", base + 8'h01, n_req);
    chk("reset cause", 8'h10, {3'h0, cause});
    rd(7'h00, 8'h88);
  end
  endtask

  // autonomous, sw-dev and forced normal
  task t_modes;
  begin
    chip_mode <= `SBCWD_CHIP_SLEEP;
    base = n_req;
    repeat (850) @(posedge clk_sys_in);
    chk("reset request", base + 8'h01, n_req);
    chk("reset cause", 8'h0c, {3'h0, cause});
    chk("fail pending", 8'h01, {7'h0, fail});
    chip_mode <= `SBCWD_CHIP_STANDBY;
    wr(7'h00, 8'h28);
    rd(7'h05, 8'h00);
    rxd <= 1'b0;
    rd(7'h05, 8'h01);
    wr(7'h74, 8'h04);
    rd(7'h05, 8'h04);
    chk("sw dev", 8'h01, {7'h0, sd});
    wr(7'h74, 8'h08);
    chip_mode <= `SBCWD_CHIP_NORMAL;
    base = n_req;
    repeat (1000) @(posedge clk_sys_in);
    rd(7'h05, 8'h08);
    chk("reset request", base, n_req);
  end
  endtask

  task final_report;
  begin
    if (err_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask

  // main sequence
  initial
  begin
    repeat (20) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    repeat (6) @(posedge clk_sys_in);
    t_reset;
    t_cfg;
    t_codes;
    t_timeout;
    t_window;
    t_modes;
    final_report;
  end

  // the run needs some 12000 cycles; cut a hang well past that
  initial
  begin
    repeat (60000) @(posedge clk_sys_in);
    err_count = err_count + 1;
    final_report;
  end
endmodule
